// File: rtl/atwc_map.svh
// register map, field positions, reset values and timing counts of the window control block
// Function
// R1 - burst off: power state follows the converter enable bit only
// R2 - burst on with enable set: converter stays powered continuously
// R3 - burst on, enable clear: power up per start, wait (field+1)*400 ns
// R4 - tracking mode 01 post, 10 pre, 11 dual; 00 reserved; dual after reset
// R5 - post-track lasts 2/4/8/16 SAR cycles plus 2 base cycles
// R6 - window detector compares result to limits, raises window match flag
// R7 - lower limit above upper: match when strictly between both limits
// R8 - lower limit not above upper: match when below lower or above upper
// R9 - unsigned result; compare in currently selected justification
// R10 - each conversion takes 13 SAR clock periods
// R11 - two extra base clock cycles start and finish each conversion
// R12 - software keeps SAR clock at or below 3 MHz with burst off; the bench runs it at 3.125 MHz, the slowest divider at its 10 ns clock
// R13 - software clears the window match flag; hardware never clears it
// R14 - in burst one start launches the whole series of conversions
// R15 - pre-track before start, post-track after start, dual does both; the block pre-tracks only while idle with power on
// R16 - window compare only on the final written result word
`ifndef ATWC_MAP_SVH
`define ATWC_MAP_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ATWC_ADDR_RES_LO 8'hbd
`define ATWC_ADDR_RES_HI 8'hbe
`define ATWC_ADDR_UP_LO 8'hc3
`define ATWC_ADDR_UP_HI 8'hc4
`define ATWC_ADDR_LOW_LO 8'hc5
`define ATWC_ADDR_LOW_HI 8'hc6
`define ATWC_ADDR_TRACK 8'hc7
`define ATWC_ADDR_CTRL 8'hc8
`define ATWC_ADDR_CFG 8'hc9
`define ATWC_ADDR_STAT 8'hca
`define ATWC_ADDR_MASK 8'hcb

// ************************************************************
// reset values
// ************************************************************
`define ATWC_RST_UP 8'hff
`define ATWC_RST_LOW 8'h00
`define ATWC_RST_TRACK 8'hff
`define ATWC_RST_CTRL 8'h00
`define ATWC_RST_CFG 8'hf8
`define ATWC_RST_ZERO 8'h00

// ************************************************************
// field positions
// ************************************************************
`define ATWC_CTRL_EN 7
`define ATWC_CTRL_BURST 6
`define ATWC_CTRL_DONE 5
`define ATWC_CTRL_BUSY 4
`define ATWC_CTRL_WIN 3
`define ATWC_CTRL_LJST 2
`define ATWC_TRK_PWR 7:4
`define ATWC_TRK_MODE 3:2
`define ATWC_TRK_POST 1:0
`define ATWC_CFG_DIV 7:3
`define ATWC_CFG_RPT 2:1
`define ATWC_ST_DONE 0
`define ATWC_ST_WIN 1
`define ATWC_MODE_POST 2'h1
`define ATWC_MODE_PRE 2'h2

// ************************************************************
// timing
// ************************************************************
`define ATWC_CLK_NS 10
`define ATWC_PWR_STEP_NS 400
`define ATWC_PWR_STEP_CYC ((`ATWC_PWR_STEP_NS + `ATWC_CLK_NS - 1) / `ATWC_CLK_NS)
`define ATWC_POST_BASE_SAR 16'h0002
`define ATWC_EDGE_CYC 16'h0002
`define ATWC_CONV_SAR 16'h000d
`define ATWC_REP_BASE 5'h02

`endif

// File: rtl/atwc_pkg.sv
// types shared by the window control block
package atwc_pkg;
  typedef enum logic [2:0] {
    ATWC_IDLE,
    ATWC_PWRUP,
    ATWC_POST,
    ATWC_POSTB,
    ATWC_SOC,
    ATWC_CONV,
    ATWC_EOC,
    ATWC_FINAL
  } atwc_state_t;
  typedef logic [15:0] atwc_word_t;
endpackage

// File: rtl/atwc_win_if.sv
// interface between the controller and the window comparator
`timescale 1ns/100ps
interface atwc_win_if;
  logic [15:0] result;
  logic [15:0] upper;
  logic [15:0] lower;
  logic match;
  modport ctrl (output result, output upper, output lower, input match);
  modport cmp (input result, input upper, input lower, output match);
endinterface

// File: rtl/atwc_window_cmp.sv
// window comparator on the result word
`timescale 1ns/100ps
module atwc_window_cmp (
  atwc_win_if.cmp win
);
  wire inside_mode;
  wire above_up;
  wire below_low;
  assign inside_mode = win.lower > win.upper;
  assign above_up = win.result > win.upper;
  assign below_low = win.result < win.lower;
  // unsigned compare on whatever justification the result word carries
  assign win.match = inside_mode ? (above_up && below_low) // R7 R9
                                 : (above_up || below_low); // R8
endmodule

// File: rtl/atwc_top.sv
// converter control: power timing, tracking sequence, window detector, registers
`timescale 1ns/100ps
`include "atwc_map.svh"
module atwc_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cnv_start,
  input wire logic [11:0] i_core_data,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_core_pwr,
  output logic o_core_track,
  output logic o_core_convert,
  output logic o_core_step,
  output logic o_busy,
  output atwc_pkg::atwc_word_t o_result
);
  import atwc_pkg::*;

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] up_lo_reg, up_hi_reg, low_lo_reg, low_hi_reg;
  logic [7:0] track_reg, cfg_reg, mask_reg;
  logic en_reg, burst_reg, ljst_reg, done_flag_reg, win_flag_reg;
  logic done_flag_next, win_flag_next;
  logic [1:0] stat_reg, stat_next;
  logic [7:0] rdata_next;
  atwc_word_t result_reg;

  wire wr_ctrl = i_wr && (i_addr == `ATWC_ADDR_CTRL);
  wire rd_stat = i_rd && (i_addr == `ATWC_ADDR_STAT);
  wire [7:0] ctrl_rd = {en_reg, burst_reg, done_flag_reg, o_busy, win_flag_reg,
                        ljst_reg, 2'h0};

  // ************************************************************
  // sequencer state
  // ************************************************************
  atwc_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [4:0] div_reg;
  logic [4:0] rep_reg, rep_next;
  logic [15:0] acc_reg, acc_next;
  logic [11:0] sample_reg;
  logic cmp_pend_reg;
  logic busy_next, pwr_next, track_next;

  wire [3:0] pwr_field = track_reg[`ATWC_TRK_PWR];
  wire [1:0] mode = track_reg[`ATWC_TRK_MODE];
  wire [1:0] post_field = track_reg[`ATWC_TRK_POST];
  wire [4:0] sar_div = cfg_reg[`ATWC_CFG_DIV];
  wire [1:0] rpt = cfg_reg[`ATWC_CFG_RPT];

  // reserved mode 00 is handled like dual tracking
  wire post_on = (mode != `ATWC_MODE_PRE); // R4 R15
  wire pre_on = (mode != `ATWC_MODE_POST); // R4 R15
  wire sar_tick = (div_reg == sar_div);
  wire [15:0] pwr_cyc = 16'((({12'h000, pwr_field} + 16'h0001) * `ATWC_PWR_STEP_CYC)); // R3
  wire [15:0] post_sar = `ATWC_POST_BASE_SAR << post_field; // R5
  wire [4:0] rep_last = (rpt == 2'h0) ? 5'h00 : 5'((`ATWC_REP_BASE << rpt) - 5'h01);
  wire start_req = i_cnv_start || (wr_ctrl && i_wdata[`ATWC_CTRL_BUSY]);
  // with burst off the converter must already be enabled to accept a start
  wire start_ok = en_reg || burst_reg;
  wire go = start_req && start_ok && (state_reg == ATWC_IDLE);
  wire [15:0] acc_sum = acc_reg + {4'h0, sample_reg};
  wire final_evt = (state_reg == ATWC_FINAL);

  atwc_win_if win ();
  assign win.result = result_reg;
  assign win.upper = {up_hi_reg, up_lo_reg};
  assign win.lower = {low_hi_reg, low_lo_reg};

  atwc_window_cmp u_cmp (
    .win(win.cmp)
  );

  // compare one cycle after the final word lands, never on partial sums
  wire win_evt = cmp_pend_reg && win.match; // R6 R16

  // ************************************************************
  // sequencer next state
  // ************************************************************
  always_comb begin
    atwc_state_t after_pwr;
    after_pwr = post_on ? ATWC_POST : ATWC_SOC;
    state_next = state_reg;
    cnt_next = cnt_reg;
    rep_next = rep_reg;
    acc_next = acc_reg;
    case (state_reg)
      ATWC_IDLE: begin
        if (go) begin
          cnt_next = 16'h0000;
          state_next = (burst_reg && !en_reg) ? ATWC_PWRUP : after_pwr; // R3
        end
      end
      ATWC_PWRUP: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == pwr_cyc - 16'h0001) begin // R3
          cnt_next = 16'h0000;
          state_next = after_pwr;
        end
      end
      ATWC_POST: begin
        if (sar_tick) begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == post_sar - 16'h0001) begin // R5
            cnt_next = 16'h0000;
            state_next = ATWC_POSTB;
          end
        end
      end
      ATWC_POSTB: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == `ATWC_EDGE_CYC - 16'h0001) begin // R5
          cnt_next = 16'h0000;
          state_next = ATWC_SOC;
        end
      end
      ATWC_SOC: begin
        cnt_next = 16'h0000;
        state_next = ATWC_CONV; // R11
      end
      ATWC_CONV: begin
        if (sar_tick) begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == `ATWC_CONV_SAR - 16'h0001) begin // R10
            state_next = ATWC_EOC;
          end
        end
      end
      ATWC_EOC: begin
        acc_next = acc_sum; // R11
        cnt_next = 16'h0000;
        if (rep_reg == rep_last) begin
          state_next = ATWC_FINAL;
        end else begin
          rep_next = rep_reg + 5'h01;
          // burst runs the series on its own; otherwise wait for the next start
          state_next = burst_reg ? after_pwr : ATWC_IDLE; // R14
        end
      end
      ATWC_FINAL: begin
        acc_next = 16'h0000;
        rep_next = 5'h00;
        state_next = ATWC_IDLE;
      end
      default: begin
        state_next = ATWC_IDLE;
      end
    endcase
  end

  // ************************************************************
  // core controls
  // ************************************************************
  wire busy_now = (state_next != ATWC_IDLE);
  // pulse opens each SAR period, so the last one still falls inside the convert window
  wire step_now = (state_next == ATWC_CONV) && ((state_reg != ATWC_CONV) || sar_tick); // R10
  always_comb begin
    busy_next = busy_now;
    if (burst_reg) begin
      pwr_next = en_reg || busy_now; // R2 R3
    end else begin
      pwr_next = en_reg; // R1
    end
    track_next = (state_next == ATWC_POST) || // R15
                 ((state_next == ATWC_IDLE) && pwr_next && pre_on); // R15
  end

  // ************************************************************
  // flags and status
  // ************************************************************
  always_comb begin
    done_flag_next = wr_ctrl ? i_wdata[`ATWC_CTRL_DONE] : done_flag_reg;
    if (final_evt) begin
      done_flag_next = 1'b1;
    end
    // only software clears it; a match in the clearing cycle still sets it
    win_flag_next = wr_ctrl ? i_wdata[`ATWC_CTRL_WIN] : win_flag_reg; // R13
    if (win_evt) begin
      win_flag_next = 1'b1; // R6
    end
    stat_next = rd_stat ? 2'h0 : stat_reg;
    if (final_evt) begin
      stat_next[`ATWC_ST_DONE] = 1'b1;
    end
    if (win_evt) begin
      stat_next[`ATWC_ST_WIN] = 1'b1;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rdata_next = `ATWC_RST_ZERO;
    if (i_rd) begin
      case (i_addr)
        `ATWC_ADDR_RES_LO: rdata_next = result_reg[7:0];
        `ATWC_ADDR_RES_HI: rdata_next = result_reg[15:8];
        `ATWC_ADDR_UP_LO: rdata_next = up_lo_reg;
        `ATWC_ADDR_UP_HI: rdata_next = up_hi_reg;
        `ATWC_ADDR_LOW_LO: rdata_next = low_lo_reg;
        `ATWC_ADDR_LOW_HI: rdata_next = low_hi_reg;
        `ATWC_ADDR_TRACK: rdata_next = track_reg;
        `ATWC_ADDR_CTRL: rdata_next = ctrl_rd;
        `ATWC_ADDR_CFG: rdata_next = cfg_reg;
        `ATWC_ADDR_STAT: rdata_next = {6'h00, stat_reg};
        `ATWC_ADDR_MASK: rdata_next = mask_reg;
        default: rdata_next = `ATWC_RST_ZERO;
      endcase
    end
  end

  // ************************************************************
  // software-written registers
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_lo_reg <= `ATWC_RST_UP;
      up_hi_reg <= `ATWC_RST_UP;
      low_lo_reg <= `ATWC_RST_LOW;
      low_hi_reg <= `ATWC_RST_LOW;
      track_reg <= `ATWC_RST_TRACK; // R4
      cfg_reg <= `ATWC_RST_CFG;
      mask_reg <= `ATWC_RST_ZERO;
      en_reg <= 1'b0;
      burst_reg <= 1'b0;
      ljst_reg <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `ATWC_ADDR_UP_LO) up_lo_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_UP_HI) up_hi_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_LOW_LO) low_lo_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_LOW_HI) low_hi_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_TRACK) track_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_CFG) cfg_reg <= i_wdata;
      if (i_addr == `ATWC_ADDR_MASK) mask_reg <= {6'h00, i_wdata[1:0]};
      if (wr_ctrl) begin
        en_reg <= i_wdata[`ATWC_CTRL_EN];
        burst_reg <= i_wdata[`ATWC_CTRL_BURST];
        ljst_reg <= i_wdata[`ATWC_CTRL_LJST];
      end
    end
  end

  // ************************************************************
  // sequencer and result registers
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ATWC_IDLE;
      cnt_reg <= 16'h0000;
      rep_reg <= 5'h00;
      acc_reg <= 16'h0000;
      sample_reg <= 12'h000;
      result_reg <= 16'h0000;
      cmp_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rep_reg <= rep_next;
      acc_reg <= acc_next;
      if (state_reg == ATWC_CONV && state_next == ATWC_EOC) sample_reg <= i_core_data;
      if (final_evt) result_reg <= ljst_reg ? {acc_reg[11:0], 4'h0} : acc_reg; // R9
      cmp_pend_reg <= final_evt; // R16
    end
  end

  // divider restarts on every phase change so each phase counts whole SAR periods
  wire div_clr = sar_tick || (state_reg == ATWC_IDLE) || (state_next != state_reg); // R5 R10
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_clr ? 5'h00 : div_reg + 5'h01;
    end
  end

  // ************************************************************
  // flags and outputs
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_flag_reg <= 1'b0;
      win_flag_reg <= 1'b0;
      stat_reg <= 2'h0;
      o_rdata <= `ATWC_RST_ZERO;
      o_irq <= 1'b0;
      o_core_pwr <= 1'b0;
      o_core_track <= 1'b0;
      o_core_convert <= 1'b0;
      o_core_step <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      done_flag_reg <= done_flag_next;
      win_flag_reg <= win_flag_next;
      stat_reg <= stat_next;
      o_rdata <= rdata_next;
      o_irq <= |(stat_next & mask_reg[1:0]);
      o_core_pwr <= pwr_next;
      o_core_track <= track_next;
      o_core_convert <= (state_next == ATWC_CONV);
      o_core_step <= step_now; // R10
      o_busy <= busy_next;
    end
  end

  assign o_result = result_reg;
endmodule

// File: tb/atwc_core_model.sv
// behavioural model of the analog sampling core behind the control block
`timescale 1ns/100ps
module atwc_core_model (
  input wire logic i_mclk,
  input wire logic i_convert,
  input wire logic [11:0] i_sample,
  output logic [11:0] o_data
);
  logic conv_d;
  always_ff @(posedge i_mclk) begin
    conv_d <= i_convert;
  end
  // result lines are valid only around a conversion; outside it they show the complement
  // so that a late or early sample by the controller gives a wrong word
  assign o_data = (i_convert || conv_d) ? i_sample : ~i_sample;
endmodule

// File: tb/atwc_checker.sv
// port-level assertions for the window control block
`timescale 1ns/100ps
module atwc_checker (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cnv_start,
  input wire logic [11:0] i_core_data,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_core_pwr,
  input wire logic o_core_track,
  input wire logic o_core_convert,
  input wire logic o_core_step,
  input wire logic o_busy,
  input wire atwc_pkg::atwc_word_t o_result
);
  import atwc_pkg::*;
  logic [4:0] step_cnt;
  // steps of the current conversion; cleared whenever the core is not converting
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_cnt <= 5'h00;
    end else if (!o_core_convert) begin
      step_cnt <= 5'h00;
    end else if (o_core_step) begin
      step_cnt <= step_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_conv_end;
    $fell(o_core_convert);
  endsequence
  sequence s_gap;
    !o_core_convert [*2];
  endsequence
  read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  step_count_a: assert property (s_conv_end |-> step_cnt == 5'h0d)
    else $error("conversion did not take 13 steps");
  step_inside_a: assert property (o_core_step |-> o_core_convert)
    else $error("step pulse outside conversion");
  conv_gap_a: assert property (s_conv_end |-> s_gap)
    else $error("conversions closer than two base cycles");
  track_hold_a: assert property (o_core_convert |-> !o_core_track)
    else $error("tracking during conversion");
  conv_power_a: assert property (o_core_convert |-> o_core_pwr)
    else $error("conversion while unpowered");
  conv_busy_a: assert property (o_core_convert |-> o_busy)
    else $error("conversion without busy");
  result_final_a: assert property ($changed(o_result) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("result changed outside a sequence");
endmodule
bind atwc_top atwc_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cnv_start(i_cnv_start),
  .i_core_data(i_core_data), .o_rdata(o_rdata), .o_irq(o_irq), .o_core_pwr(o_core_pwr),
  .o_core_track(o_core_track), .o_core_convert(o_core_convert), .o_core_step(o_core_step),
  .o_busy(o_busy), .o_result(o_result));

// File: tb/tb_top.sv
// self-checking bench for the window control block
`timescale 1ns/100ps
module tb_top;
  import atwc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n, i_wr, i_rd, i_cnv_start;
  logic [7:0] i_addr, i_wdata, o_rdata, v;
  logic [11:0] core_data;
  logic [11:0] sample = 12'h000;
  logic o_irq, o_core_pwr, o_core_track, o_core_convert, o_core_step, o_busy;
  atwc_word_t o_result;
  int failures = 0;
  int n_compared = 0;
  int lat, nconv;
  logic [7:0] r_a [6] = '{8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hd0};
  logic [7:0] r_v [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
  logic [15:0] t_up [6] = '{16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200, 16'h1000};
  logic [15:0] t_low [6] = '{16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h2000};
  logic [11:0] t_s [6] = '{12'h180, 12'h200, 12'h050, 12'h150, 12'h201, 12'h180};
  logic [5:0] t_m = 6'b110101;
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  atwc_top uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_cnv_start(i_cnv_start), .i_core_data(core_data),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_core_pwr(o_core_pwr), .o_core_track(o_core_track),
    .o_core_convert(o_core_convert), .o_core_step(o_core_step), .o_busy(o_busy),
    .o_result(o_result));
  atwc_core_model u_core (.i_mclk(i_mclk), .i_convert(o_core_convert), .i_sample(sample),
    .o_data(core_data));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_mclk);
  endtask
  // one start pulse; measures cycles to the first conversion and counts conversions
  task automatic conv();
    logic prev;
    i_cnv_start <= 1'b1;
    @(posedge i_mclk);
    i_cnv_start <= 1'b0;
    lat = 0;
    nconv = 0;
    prev = 1'b0;
    for (int n = 1; n < 20000; n++) begin
      #1;
      if (o_core_convert === 1'b1 && !prev) begin
        nconv++;
        if (lat == 0) lat = n;
      end
      prev = (o_core_convert === 1'b1);
      if (o_busy !== 1'b1 && n > 1) break;
      @(posedge i_mclk);
    end
    chk("busy end", 16'(o_busy), 16'h0000);
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    conclude();
  end
  initial begin
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cnv_start = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    wr(8'hd0, 8'h5a);
    for (int k = 0; k < 6; k++) begin
      rd(r_a[k], v);
      chk("reset value", 16'(v), 16'(r_v[k]));
    end
    $display("test reset done");
    // slowest divider keeps the SAR clock as close to its limit as this base clock allows
    wr(8'hc9, 8'hf8);
    wr(8'hcb, 8'h02);
    for (int i = 0; i < 6; i++) begin
      wr(8'hc3, t_up[i][7:0]);
      wr(8'hc4, t_up[i][15:8]);
      wr(8'hc5, t_low[i][7:0]);
      wr(8'hc6, t_low[i][15:8]);
      wr(8'hc7, 8'h04 | 8'(i % 4));
      wr(8'hc8, (i == 5) ? 8'h84 : 8'h80);
      sample <= t_s[i];
      conv();
      chk("post latency", 16'(lat), 16'((2 << (i % 4)) * 32 + 4));
      chk("result", o_result, (i == 5) ? {t_s[i], 4'h0} : {4'h0, t_s[i]});
      chk("irq", 16'(o_irq), 16'(t_m[i]));
      rd(8'hca, v);
      chk("status", 16'(v), {14'h0000, t_m[i], 1'b1});
      rd(8'hc8, v);
      chk("match flag", 16'(v[3]), 16'(t_m[i]));
      #1 chk("irq cleared", 16'(o_irq), 16'h0000);
    end
    $display("test window done");
    wr(8'hc9, 8'hfa);
    wr(8'hc7, 8'h14);
    wr(8'hc8, 8'h40);
    sample <= 12'h123;
    conv();
    chk("burst latency", 16'(lat), 16'(80 + 68));
    chk("burst count", 16'(nconv), 16'h0004);
    chk("burst sum", o_result, 16'h048c);
    #1 chk("burst idle power", 16'(o_core_pwr), 16'h0000);
    wr(8'hc8, 8'hc0);
    conv();
    chk("burst on latency", 16'(lat), 16'h0044);
    #1 chk("burst on power", 16'(o_core_pwr), 16'h0001);
    wr(8'hc9, 8'hf8);
    wr(8'hc8, 8'h80);
    #1 chk("enabled power", 16'(o_core_pwr), 16'h0001);
    wr(8'hc7, 8'h08);
    #1 chk("pre track", 16'(o_core_track), 16'h0001);
    conv();
    chk("pre latency", 16'(lat), 16'h0002);
    wr(8'hc7, 8'h0c);
    conv();
    chk("dual latency", 16'(lat), 16'h0044);
    wr(8'hc8, 8'h00);
    #1 chk("disabled power", 16'(o_core_pwr), 16'h0000);
    conv();
    chk("refused start", 16'(nconv), 16'h0000);
    $display("test power done");
    conclude();
  end
endmodule
